// ===== design/pfs_pkg.sv
// What this block does
// - Running processor reads and writes program flash through indirect registers.
// - Exactly six special registers: control, unlock, data low/high, address low/high.
// - Data low and high form one 14-bit word for reads and writes.
// - Address low and high form a 13-bit word address.
// - Flash holds 2K words at addresses 0000h to 07FFh.
// - Address pair expresses up to 8K words.
// - Reads fetch one word; writes cover four words, erasing before programming.
// - An internal timer times each erase and program.
// - Self read and write keep working while code protection is on.
// - Write-protect select blocks self-writes to regions; reads always allowed.
// - Code protect active refuses the serial programmer all memory access.
// - Read and write triggers are set-only; hardware clears them on completion.
// - A flash write starts only while write permit is set.
// - Write permit is clear after power-up.
// - Unlock port has no storage and reads as zero.
// - Unlock port writes only feed the write sequence detector.
// - 55h then AAh to unlock port precede each buffer load or program.
// - Read fetches in second instruction cycle, suppresses it, holds data.
// - Buffer goes to flash only when low address bits are 11.
// - Control register: permit bit 2, write trigger bit 1, read trigger bit 0.
package pfs_pkg;

  localparam int SREG_AW = 8;
  localparam int SREG_DW = 8;
  localparam int WORD_W  = 14;
  localparam int ADDR_W  = 13;
  localparam int MEM_AW  = 11;
  localparam int MEM_DEPTH = 2048;
  localparam int DATA_HI_W = 6;
  localparam int ADDR_HI_W = 5;
  localparam int BLOCK_WORDS = 4;

  // Special register offsets
  localparam logic [7:0] OFS_CONTROL   = 8'h93;
  localparam logic [7:0] OFS_UNLOCK    = 8'h94;
  localparam logic [7:0] OFS_ADDR_LOW  = 8'h95;
  localparam logic [7:0] OFS_ADDR_HIGH = 8'h96;
  localparam logic [7:0] OFS_DATA_LOW  = 8'h9a;
  localparam logic [7:0] OFS_DATA_HIGH = 8'h9b;

  // Control register fields
  localparam int CTL_RD_BIT     = 0;
  localparam int CTL_WR_BIT     = 1;
  localparam int CTL_PERMIT_BIT = 2;
  localparam int CTL_ONE_BIT    = 7;

  localparam logic [7:0] RST_BYTE   = 8'h00;
  localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
  localparam logic [7:0] UNLOCK_KEY2 = 8'haa;
  localparam logic [13:0] ERASED_WORD = 14'h3fff;
  localparam logic [1:0] BLOCK_LAST  = 2'h3;
  localparam logic [1:0] WP_OFF      = 2'h3;
  localparam logic [1:0] WP_LOW      = 2'h2;
  localparam logic [1:0] WP_HALF     = 2'h1;
  localparam logic [12:0] WP_LOW_END  = 13'h00ff;
  localparam logic [12:0] WP_HALF_END = 13'h03ff;
  localparam logic [12:0] IMPL_LAST   = 13'h07ff;

  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int PROG_TIME_NS  = 2000000;
  localparam int PROG_CYCLES   = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ST_IDLE, ST_RD_WAIT, ST_RD_LOAD, ST_ERASE, ST_PROG
  } pfs_state_t;

  typedef enum logic [1:0] {
    UL_IDLE, UL_GOT_FIRST, UL_ARMED
  } pfs_unlock_t;

  function automatic logic wp_blocked(input logic [12:0] addr, input logic [1:0] sel);
    case (sel)
      WP_OFF:  wp_blocked = 1'b0;
      WP_LOW:  wp_blocked = (addr <= WP_LOW_END);
      WP_HALF: wp_blocked = (addr <= WP_HALF_END);
      default: wp_blocked = (addr <= IMPL_LAST);
    endcase
  endfunction : wp_blocked

endpackage : pfs_pkg

// ===== design/pfs_mem_if.sv
`timescale 1ns/1ns
interface pfs_mem_if;
  logic        rd_en;
  logic        wr_en;
  logic [10:0] addr;
  logic [13:0] wdata;
  logic [13:0] rdata;
  modport ctrl (output rd_en, output wr_en, output addr, output wdata, input rdata);
  modport mem  (input rd_en, input wr_en, input addr, input wdata, output rdata);
endinterface : pfs_mem_if

// ===== design/pfs_flash_array.sv
`timescale 1ns/1ns
module pfs_flash_array (
  input wire logic ref_clk,
  pfs_mem_if.mem   m
);
  import pfs_pkg::*;

  logic [WORD_W-1:0] cells [MEM_DEPTH];

  // Flash cells keep content across reset
  always_ff @(posedge ref_clk) begin
    if (m.wr_en) begin
      cells[m.addr] <= m.wdata;
    end
    if (m.rd_en) begin
      m.rdata <= cells[m.addr];
    end
  end
endmodule : pfs_flash_array

// ===== design/pfs_prog_timer.sv
`timescale 1ns/1ns
module pfs_prog_timer #(
  parameter int CYCLES = 20000
) (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic start,
  output logic      busy,
  output logic      done
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] count;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      count <= '0;
      busy  <= 1'b0;
      done  <= 1'b0;
    end else begin
      done <= busy && (count == LAST);
      if (start) begin
        busy  <= 1'b1;
        count <= '0;
      end else if (busy) begin
        busy  <= (count != LAST);
        count <= count + 1'b1;
      end
    end
  end
endmodule : pfs_prog_timer

// ===== design/pfs_program_flash_self_access.sv
`timescale 1ns/1ns
module pfs_program_flash_self_access #(
  parameter int PROG_CYCLES_P = pfs_pkg::PROG_CYCLES
) (
  input  wire logic                        ref_clk,
  input  wire logic                        rst_n,
  input  wire logic                        instr_cycle_en,
  input  wire logic [pfs_pkg::SREG_AW-1:0] sreg_addr,
  input  wire logic                        sreg_wr,
  input  wire logic                        sreg_rd,
  input  wire logic [pfs_pkg::SREG_DW-1:0] sreg_wdata,
  output logic      [pfs_pkg::SREG_DW-1:0] sreg_rdata,
  input  wire logic [1:0]                  write_protect_select,
  input  wire logic                        code_protect_n,
  input  wire logic                        prog_rd_req,
  input  wire logic [pfs_pkg::ADDR_W-1:0]  prog_addr,
  output logic      [pfs_pkg::WORD_W-1:0]  prog_rdata,
  output logic                             prog_rvalid,
  output logic                             prog_denied,
  output logic                             core_suppress,
  output logic                             core_stall
);
  import pfs_pkg::*;

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic [7:0]           data_low;
  logic [DATA_HI_W-1:0] data_high;
  logic [7:0]           addr_low;
  logic [ADDR_HI_W-1:0] addr_high;
  logic                 rd_bit;
  logic                 wr_bit;
  logic                 permit;
  logic [WORD_W-1:0]    wbuf [BLOCK_WORDS];
  pfs_state_t           state;
  pfs_unlock_t          unlock_st;
  logic                 rd_lag;
  logic [2:0]           blk_idx;
  logic                 prog_pend;
  logic                 tmr_busy;
  logic                 tmr_done;

  pfs_mem_if mem_bus ();

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire hit_ctrl   = sreg_wr && (sreg_addr == OFS_CONTROL);
  wire hit_unlock = sreg_wr && (sreg_addr == OFS_UNLOCK);
  wire hit_dlow   = sreg_wr && (sreg_addr == OFS_DATA_LOW);
  wire hit_dhigh  = sreg_wr && (sreg_addr == OFS_DATA_HIGH);
  wire hit_alow   = sreg_wr && (sreg_addr == OFS_ADDR_LOW);
  wire hit_ahigh  = sreg_wr && (sreg_addr == OFS_ADDR_HIGH);

  wire [ADDR_W-1:0] full_addr = {addr_high, addr_low};
  wire [WORD_W-1:0] full_data = {data_high, data_low};
  wire              addr_impl = (full_addr <= IMPL_LAST);
  wire              is_idle   = (state == ST_IDLE);
  wire              armed     = (unlock_st == UL_ARMED);

  // Write trigger needs the key just before, permit, and an unprotected location
  wire wr_try     = hit_ctrl && sreg_wdata[CTL_WR_BIT] && !wr_bit;
  wire wr_ok      = wr_try && armed && permit && is_idle && addr_impl
                    && !wp_blocked(full_addr, write_protect_select);
  wire blk_commit = wr_ok && (full_addr[1:0] == BLOCK_LAST);
  wire rd_try     = hit_ctrl && sreg_wdata[CTL_RD_BIT] && !rd_bit && is_idle && !wr_ok;
  // Self access is not gated by code protection
  wire rd_issue   = (state == ST_RD_WAIT) && instr_cycle_en && rd_lag;
  wire prog_serve = prog_rd_req && code_protect_n && is_idle && !rd_try && !wr_ok;
  wire wr_phase   = (state == ST_ERASE) || (state == ST_PROG);
  wire blk_write  = wr_phase && !blk_idx[2];

  // ----------------------------------------
  // Flash port selection
  // ----------------------------------------
  assign mem_bus.rd_en = rd_issue || prog_serve;
  assign mem_bus.wr_en = blk_write;
  assign mem_bus.addr  = wr_phase   ? {full_addr[MEM_AW-1:2], blk_idx[1:0]} :
                         prog_serve ? prog_addr[MEM_AW-1:0] :
                                      full_addr[MEM_AW-1:0];
  // Erase pass writes the erased pattern, program pass the buffer
  assign mem_bus.wdata = (state == ST_ERASE) ? ERASED_WORD : wbuf[blk_idx[1:0]];

  pfs_flash_array u_array (
    .ref_clk (ref_clk),
    .m       (mem_bus)
  );

  pfs_prog_timer #(
    .CYCLES (PROG_CYCLES_P)
  ) u_timer (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .start   (wr_phase && (blk_idx == 3'h0)),
    .busy    (tmr_busy),
    .done    (tmr_done)
  );

  // ----------------------------------------
  // Register read mux
  // ----------------------------------------
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = RST_BYTE;
    case (sreg_addr)
      OFS_CONTROL: begin
        rd_mux[CTL_ONE_BIT]    = 1'b1;
        rd_mux[CTL_PERMIT_BIT] = permit;
        rd_mux[CTL_WR_BIT]     = wr_bit;
        rd_mux[CTL_RD_BIT]     = rd_bit;
      end
      OFS_UNLOCK:    rd_mux = RST_BYTE;
      OFS_DATA_LOW:  rd_mux = data_low;
      OFS_DATA_HIGH: rd_mux = {2'h0, data_high};
      OFS_ADDR_LOW:  rd_mux = addr_low;
      OFS_ADDR_HIGH: rd_mux = {3'h0, addr_high};
      default:       rd_mux = RST_BYTE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sreg_rdata <= RST_BYTE;
    end else if (sreg_rd) begin
      sreg_rdata <= rd_mux;
    end
  end

  // ----------------------------------------
  // Unlock sequence detector
  // ----------------------------------------
  // Any other register write breaks the sequence, so it must come right before the trigger
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      unlock_st <= UL_IDLE;
    end else if (hit_unlock) begin
      case (unlock_st)
        UL_IDLE:      unlock_st <= (sreg_wdata == UNLOCK_KEY1) ? UL_GOT_FIRST : UL_IDLE;
        UL_GOT_FIRST: unlock_st <= (sreg_wdata == UNLOCK_KEY2) ? UL_ARMED : UL_IDLE;
        default:      unlock_st <= (sreg_wdata == UNLOCK_KEY1) ? UL_GOT_FIRST : UL_IDLE;
      endcase
    end else if (sreg_wr) begin
      unlock_st <= UL_IDLE;
    end
  end

  // ----------------------------------------
  // Address and data registers
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      addr_low  <= RST_BYTE;
      addr_high <= '0;
    end else begin
      if (hit_alow) begin
        addr_low <= sreg_wdata;
      end
      if (hit_ahigh) begin
        addr_high <= sreg_wdata[ADDR_HI_W-1:0];
      end
    end
  end

  // Read result holds until the next read or a software write
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      data_low  <= RST_BYTE;
      data_high <= '0;
    end else if (state == ST_RD_LOAD) begin
      data_low  <= mem_bus.rdata[7:0];
      data_high <= mem_bus.rdata[WORD_W-1:8];
    end else begin
      if (hit_dlow) begin
        data_low <= sreg_wdata;
      end
      if (hit_dhigh) begin
        data_high <= sreg_wdata[DATA_HI_W-1:0];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (wr_ok) begin
      wbuf[full_addr[1:0]] <= full_data;
    end
  end

  // ----------------------------------------
  // Control bits and sequencer
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      permit  <= 1'b0;
      rd_bit  <= 1'b0;
      wr_bit  <= 1'b0;
      state   <= ST_IDLE;
      rd_lag  <= 1'b0;
      blk_idx <= 3'h0;
      core_stall    <= 1'b0;
      core_suppress <= 1'b0;
    end else begin
      if (hit_ctrl) begin
        permit <= sreg_wdata[CTL_PERMIT_BIT];
      end
      if (instr_cycle_en) begin
        core_suppress <= 1'b0;
      end
      case (state)
        ST_IDLE: begin
          wr_bit <= 1'b0;
          if (blk_commit) begin
            wr_bit     <= 1'b1;
            core_stall <= 1'b1;
            blk_idx    <= 3'h0;
            state      <= ST_ERASE;
          end else if (wr_ok) begin
            wr_bit <= 1'b1;
          end else if (rd_try) begin
            rd_bit <= 1'b1;
            rd_lag <= 1'b0;
            state  <= ST_RD_WAIT;
          end
        end
        ST_RD_WAIT: begin
          if (instr_cycle_en) begin
            rd_lag <= 1'b1;
            if (rd_lag) begin
              core_suppress <= 1'b1;
              state         <= ST_RD_LOAD;
            end
          end
        end
        ST_RD_LOAD: begin
          rd_bit <= 1'b0;
          state  <= ST_IDLE;
        end
        ST_ERASE: begin
          if (!blk_idx[2]) begin
            blk_idx <= blk_idx + 3'h1;
          end
          if (tmr_done) begin
            blk_idx <= 3'h0;
            state   <= ST_PROG;
          end
        end
        ST_PROG: begin
          if (!blk_idx[2]) begin
            blk_idx <= blk_idx + 3'h1;
          end
          if (tmr_done) begin
            wr_bit     <= 1'b0;
            core_stall <= 1'b0;
            state      <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Serial programmer read port
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      prog_pend   <= 1'b0;
      prog_rvalid <= 1'b0;
      prog_denied <= 1'b0;
      prog_rdata  <= '0;
    end else begin
      prog_pend   <= prog_serve;
      prog_rvalid <= prog_pend;
      prog_denied <= prog_rd_req && !code_protect_n;
      if (prog_pend) begin
        prog_rdata <= mem_bus.rdata;
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  AST_UNLOCK_ZERO: assert property (
    sreg_rd && (sreg_addr == OFS_UNLOCK) |=> (sreg_rdata == RST_BYTE))
    else $error("unlock port read not zero");
  AST_WR_NEEDS_KEY: assert property (
    $rose(wr_bit) |-> ($past(unlock_st) == UL_ARMED) && $past(permit))
    else $error("write trigger set without key or permit");
  AST_RD_HELD: assert property (
    rd_bit && (state != ST_RD_LOAD) |=> rd_bit)
    else $error("read trigger cleared early");
  AST_BLOCK_LAST: assert property (
    (state == ST_ERASE) && ($past(state) == ST_IDLE) |-> ($past(full_addr[1:0]) == BLOCK_LAST))
    else $error("block program from non-last word");
  AST_WP_RESPECT: assert property (
    $rose(wr_bit) |-> !wp_blocked($past(full_addr), $past(write_protect_select)))
    else $error("write into protected region");
  AST_STALL: assert property (
    wr_phase |-> core_stall && wr_bit)
    else $error("core not stalled during program");
  AST_READ_LAG: assert property (
    rd_issue |=> core_suppress && (state == ST_RD_LOAD) ##1 !rd_bit && (data_low == $past(mem_bus.rdata[7:0])))
    else $error("read result not loaded on time");
  AST_ERASE_FIRST: assert property (
    (state == ST_PROG) |-> ($past(state) == ST_ERASE) || ($past(state) == ST_PROG))
    else $error("program without erase");
  AST_CP_DENY: assert property (
    prog_rd_req && !code_protect_n |=> prog_denied ##1 !prog_rvalid)
    else $error("protected programmer access served");
  AST_PERMIT: assert property (
    $rose(wr_bit) |-> $past(permit))
    else $error("write started without permit");
  AST_TIMER_RUN: assert property (
    wr_phase && (blk_idx != 3'h0) |-> tmr_busy || tmr_done)
    else $error("write phase left without a running timer");

endmodule : pfs_program_flash_self_access

// ===== verification/pfs_core_model.sv
`timescale 1ns/1ns
module pfs_core_model (
  input  wire logic                        ref_clk,
  output logic                             instr_cycle_en,
  output logic      [pfs_pkg::SREG_AW-1:0] sreg_addr,
  output logic                             sreg_wr,
  output logic                             sreg_rd,
  output logic      [pfs_pkg::SREG_DW-1:0] sreg_wdata,
  input  wire logic [pfs_pkg::SREG_DW-1:0] sreg_rdata,
  output int                               pulse_total
);
  import pfs_pkg::*;
  int phase;
  // ----------------------------------------
  // Instruction cycle: one pulse every four clocks
  // ----------------------------------------
  initial begin
    phase = 0;
    pulse_total = 0;
    instr_cycle_en = 1'b0;
    sreg_addr = 8'h00;
    sreg_wr = 1'b0;
    sreg_rd = 1'b0;
    sreg_wdata = 8'h00;
  end
  always @(posedge ref_clk) begin
    phase <= (phase + 1) % 4;
    instr_cycle_en <= #1 (phase == 3);
    if (instr_cycle_en === 1'b1)
      pulse_total <= pulse_total + 1;
  end
  // ----------------------------------------
  // Register bus cycles
  // ----------------------------------------
  task automatic sreg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    sreg_addr = a;
    sreg_wdata = d;
    sreg_wr = 1'b1;
    @(posedge ref_clk);
    #1;
    sreg_wr = 1'b0;
    sreg_wdata = ~d;  // Released bus must not keep the old value
  endtask : sreg_write
  task automatic sreg_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    #1;
    sreg_addr = a;
    sreg_rd = 1'b1;
    @(posedge ref_clk);
    #1;
    sreg_rd = 1'b0;
    d = sreg_rdata;
  endtask : sreg_read
  task automatic set_addr(input logic [12:0] a);
    sreg_write(OFS_ADDR_HIGH, {3'h0, a[12:8]});
    sreg_write(OFS_ADDR_LOW, a[7:0]);
  endtask : set_addr
  task automatic unlock_trigger(input logic [7:0] ctl);
    sreg_write(OFS_UNLOCK, UNLOCK_KEY1);
    sreg_write(OFS_UNLOCK, UNLOCK_KEY2);
    sreg_write(OFS_CONTROL, ctl);
  endtask : unlock_trigger
endmodule : pfs_core_model

// ===== verification/pfs_program_flash_self_access_bench.sv
`timescale 1ns/1ns
module pfs_program_flash_self_access_bench;
  import pfs_pkg::*;
  localparam int PC = 8;
  logic        ref_clk, rst_n, instr_cycle_en, sreg_wr, sreg_rd, cpn, prog_rd_req;
  logic        prog_rvalid, prog_denied, core_suppress, core_stall;
  logic [7:0]  sreg_addr, sreg_wdata, sreg_rdata, v, vh;
  logic [1:0]  wps;
  logic [12:0] prog_addr;
  logic [13:0] prog_rdata;
  int          fail_count = 0;
  int          check_count = 0;
  int          pulses;
  logic [13:0] words [4] = '{14'h0a5c, 14'h3001, 14'h1e2d, 14'h2b7f};

  pfs_program_flash_self_access #(.PROG_CYCLES_P(PC)) pfs_program_flash_self_access_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .instr_cycle_en(instr_cycle_en), .sreg_addr(sreg_addr),
    .sreg_wr(sreg_wr), .sreg_rd(sreg_rd), .sreg_wdata(sreg_wdata), .sreg_rdata(sreg_rdata),
    .write_protect_select(wps), .code_protect_n(cpn), .prog_rd_req(prog_rd_req),
    .prog_addr(prog_addr), .prog_rdata(prog_rdata), .prog_rvalid(prog_rvalid),
    .prog_denied(prog_denied), .core_suppress(core_suppress), .core_stall(core_stall));
  pfs_core_model pfs_core_model_i (
    .ref_clk(ref_clk), .instr_cycle_en(instr_cycle_en), .sreg_addr(sreg_addr), .sreg_wr(sreg_wr),
    .sreg_rd(sreg_rd), .sreg_wdata(sreg_wdata), .sreg_rdata(sreg_rdata), .pulse_total(pulses));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // ----------------------------------------
  // Checking and waiting
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check
  task automatic final_report;
    if (fail_count == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  task automatic wait_for(input bit sup, input logic lvl, input int lim, output int n);
    n = 0;
    while (((sup ? core_suppress : core_stall) !== lvl) && n < lim) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (n >= lim) begin
      fail_count++;
      final_report();
    end
  endtask : wait_for
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    pfs_core_model_i.sreg_read(a, v);
    check(v, exp);
  endtask : rd
  task automatic write_word(input logic [12:0] a, input logic [13:0] d);
    pfs_core_model_i.set_addr(a);
    pfs_core_model_i.sreg_write(OFS_DATA_LOW, d[7:0]);
    pfs_core_model_i.sreg_write(OFS_DATA_HIGH, {2'h0, d[13:8]});
    pfs_core_model_i.unlock_trigger(8'h06);
  endtask : write_word
  task automatic read_word(input logic [12:0] a, input logic [13:0] exp);
    int n0;
    int n;
    pfs_core_model_i.set_addr(a);
    pfs_core_model_i.sreg_write(OFS_CONTROL, 8'h05);
    n0 = pulses;
    pfs_core_model_i.sreg_write(OFS_CONTROL, 8'h04);
    wait_for(1'b1, 1'b1, 20, n);
    check(pulses - n0, 2);
    wait_for(1'b1, 1'b0, 8, n);
    rd(OFS_CONTROL, 8'h84);
    pfs_core_model_i.sreg_read(OFS_DATA_LOW, v);
    pfs_core_model_i.sreg_read(OFS_DATA_HIGH, vh);
    check({vh, v}, {2'h0, exp});
  endtask : read_word
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    rd(OFS_CONTROL, 8'h80);
    rd(OFS_DATA_LOW, RST_BYTE);
    rd(OFS_ADDR_LOW, RST_BYTE);
    rd(OFS_UNLOCK, 8'h00);
    rd(8'h97, 8'h00);
  endtask : t_reset
  task automatic t_regs;
    pfs_core_model_i.set_addr(13'h1fa5);
    rd(OFS_ADDR_HIGH, 8'h1f);
    rd(OFS_ADDR_LOW, 8'ha5);
    pfs_core_model_i.sreg_write(OFS_DATA_HIGH, 8'hff);
    pfs_core_model_i.sreg_write(OFS_DATA_LOW, 8'h5a);
    rd(OFS_DATA_HIGH, 8'h3f);
    rd(OFS_DATA_LOW, 8'h5a);
    pfs_core_model_i.sreg_write(OFS_UNLOCK, UNLOCK_KEY1);
    pfs_core_model_i.sreg_write(8'h97, 8'h33);
    rd(OFS_UNLOCK, 8'h00);
    rd(OFS_CONTROL, 8'h80);
    rd(8'h97, 8'h00);
  endtask : t_regs
  task automatic t_permit;
    write_word(13'h0107, 14'h0111);
    repeat (3) @(posedge ref_clk);
    #1;
    check(core_stall, 1'b0);
    rd(OFS_CONTROL, 8'h84);
    pfs_core_model_i.sreg_write(OFS_UNLOCK, UNLOCK_KEY1);
    pfs_core_model_i.sreg_write(OFS_UNLOCK, UNLOCK_KEY2);
    pfs_core_model_i.sreg_write(OFS_DATA_LOW, 8'h11);
    pfs_core_model_i.sreg_write(OFS_CONTROL, 8'h06);
    repeat (3) @(posedge ref_clk);
    #1;
    check(core_stall, 1'b0);
    rd(OFS_CONTROL, 8'h84);
    write_word(13'h0807, 14'h0333);
    repeat (3) @(posedge ref_clk);
    #1;
    check(core_stall, 1'b0);
    rd(OFS_CONTROL, 8'h84);
  endtask : t_permit
  task automatic t_block;
    int n;
    for (int i = 0; i < 3; i++) begin
      write_word(13'h0104 + i, words[i]);
      check(core_stall, 1'b0);
    end
    write_word(13'h0107, words[3]);
    wait_for(1'b0, 1'b1, 4, n);
    rd(OFS_CONTROL, 8'h86);
    wait_for(1'b0, 1'b0, 100, n);
    check(n + 2 >= 2 * PC, 1'b1);
    rd(OFS_CONTROL, 8'h84);
    for (int i = 0; i < 4; i++)
      read_word(13'h0104 + i, words[i]);
  endtask : t_block
  task automatic t_protect;
    wps = WP_LOW;
    write_word(13'h0003, 14'h0222);
    repeat (3) @(posedge ref_clk);
    #1;
    check(core_stall, 1'b0);
    rd(OFS_CONTROL, 8'h84);
    wps = WP_HALF;
    write_word(13'h0203, 14'h0444);
    repeat (3) @(posedge ref_clk);
    #1;
    check(core_stall, 1'b0);
    rd(OFS_CONTROL, 8'h84);
    wps = 2'h0;
    cpn = 1'b0;
    read_word(13'h0105, words[1]);
  endtask : t_protect
  task automatic t_prog(input logic prot, input logic [12:0] a, input logic [13:0] exp);
    logic dn;
    logic vd;
    logic [13:0] d;
    dn = 1'b0;
    vd = 1'b0;
    d = 14'h0;
    cpn = ~prot;
    @(posedge ref_clk);
    #1;
    prog_addr = a;
    prog_rd_req = 1'b1;
    @(posedge ref_clk);
    #1;
    prog_rd_req = 1'b0;
    prog_addr = ~a;
    repeat (4) begin
      dn = dn | prog_denied;
      if (prog_rvalid === 1'b1) begin
        vd = 1'b1;
        d = prog_rdata;
      end
      @(posedge ref_clk);
      #1;
    end
    check({dn, vd}, {prot, ~prot});
    check(d, prot ? 14'h0 : exp);
  endtask : t_prog
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst_n = 1'b0;
    wps = WP_OFF;
    cpn = 1'b1;
    prog_rd_req = 1'b0;
    prog_addr = 13'h0;
    repeat (3) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    t_reset();
    t_regs();
    t_permit();
    t_block();
    t_protect();
    t_prog(1'b1, 13'h0106, words[2]);
    t_prog(1'b0, 13'h0106, words[2]);
    final_report();
  end
endmodule : pfs_program_flash_self_access_bench
